// >>> core/fcc_ctrl_unit.sv
// fcc_ctrl_unit: control commands of a floppy controller (seek, recalibrate, read id,
// sense interrupt, sense drive, timing) behind an APB slave, for four drives
// assumes synchronous drive inputs and a data path that reports id fields and byte requests
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module fcc_ctrl_unit #(
  parameter int unsigned TICK_CYC = fcc_pkg::TICK_CYC_DEF
) (
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic [fcc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [3:0]                  trackZero,
  input  wire logic                        indexPulse,
  input  wire logic                        idValid,
  input  wire logic [31:0]                 idField,
  input  wire logic                        lowPower,
  input  wire logic                        rwStart,
  input  wire logic                        rwEnd,
  input  wire logic                        resultEnter,
  input  wire logic                        byteReq,
  output logic      [3:0]                  stepPulse,
  output logic      [3:0]                  stepDir,
  output logic                             intOut,
  output logic                             transferRequest,
  output logic                             transferIntr,
  output logic                             headLoad,
  output logic                             headReady,
  output logic      [5:0]                  gap2Len
);
  import fcc_pkg::*;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  fcc_state_t  state_r;
  logic [3:0]  stepCode_r, unloadCode_r;
  logic [6:0]  loadCode_r;
  logic        nonDma_r, perp_r;
  logic [1:0]  rate_r;
  logic [3:0]  cmdOp_r;
  logic [1:0]  cmdDrv_r;
  logic [7:0]  cmdCyl_r;
  logic [7:0]  pcn_r [4];
  logic [7:0]  ncn_r [4];
  logic [1:0]  posMode_r [4];
  logic [6:0]  recalCnt_r [4];
  logic [7:0]  drvSt0_r [4];
  logic [3:0]  doneEv_r;
  logic [3:0]  drvPend_r;
  logic        pollPend_r, otherPend_r;
  logic [7:0]  resSt0_r, resPcn_r, resSt1_r, st3_r;
  logic [31:0] idCap_r;
  logic [1:0]  idxCnt_r;
  logic        idxDly_r, lowDly_r;
  logic [19:0] tickCnt_r;
  logic        tick_r;
  logic [8:0]  stepTmr_r;
  logic        stepNow_r;
  logic [7:0]  pulseCnt_r;
  logic [8:0]  headTmr_r;
  logic        unloading_r;
  logic        accessNow, wrEn, lpExit, idxRise, cmdWr, inCmd;
  logic [19:0] tickLen;
  logic [8:0]  stepTicks, loadTicks, unloadTicks;

  localparam logic [1:0] POS_IDLE  = 2'h0;
  localparam logic [1:0] POS_SEEK  = 2'h1;
  localparam logic [1:0] POS_RECAL = 2'h2;

  assign accessNow = psel & penable & ~pready;
  // a write lands on the edge where the master samples pready high
  assign wrEn      = psel & penable & pwrite & pready;
  assign cmdWr     = wrEn & (paddr == OFF_CMD) & (state_r == ST_IDLE);
  assign inCmd     = (state_r == ST_CMD);
  assign lpExit    = lowDly_r & ~lowPower;
  assign idxRise   = indexPulse & ~idxDly_r;

  // ------------------------------------------------------------
  // apb slave, one wait state
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= accessNow;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (accessNow) begin
        unique case (paddr)
          OFF_CMD:    prdata <= {16'h0000, cmdCyl_r, 2'b00, cmdDrv_r, cmdOp_r};
          OFF_TIMING: prdata <= {13'h0000, perp_r, rate_r, nonDma_r, loadCode_r,
                                 unloadCode_r, stepCode_r};
          // busy drops after the command phase (after the id search for read id), per-drive busy stays until sensed
          OFF_STATUS: prdata <= {24'h000000, headReady, transferIntr, intOut,
                                 drvPend_r | doneEv_r | {(posMode_r[3] != POS_IDLE),
                                 (posMode_r[2] != POS_IDLE), (posMode_r[1] != POS_IDLE),
                                 (posMode_r[0] != POS_IDLE)},
                                 (state_r != ST_IDLE)};
          OFF_RESULT: prdata <= {8'h00, resSt1_r, resPcn_r, resSt0_r};
          OFF_IDCAP:  prdata <= idCap_r;
          OFF_CYL:    prdata <= {pcn_r[3], pcn_r[2], pcn_r[1], pcn_r[0]};
          OFF_DRVST:  prdata <= {24'h000000, st3_r};
          default:    pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // timing command
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stepCode_r   <= STEP_CODE_RST;
      unloadCode_r <= UNLOAD_CODE_RST;
      loadCode_r   <= LOAD_CODE_RST;
      nonDma_r     <= 1'b0;
      rate_r       <= RATE_RST;
      perp_r       <= 1'b0;
    end else if (wrEn && paddr == OFF_TIMING) begin
      stepCode_r   <= pwdata[TIM_STEP_LSB +: 4];
      unloadCode_r <= pwdata[TIM_UNLOAD_LSB +: 4];
      loadCode_r   <= pwdata[TIM_LOAD_LSB +: 7];
      nonDma_r     <= pwdata[TIM_MODE_BIT];
      rate_r       <= pwdata[TIM_RATE_LSB +: 2];
      perp_r       <= pwdata[TIM_PERP_BIT];
    end
  end

  // ------------------------------------------------------------
  // rate-scaled tick and delay lengths
  // ------------------------------------------------------------
  always_comb begin
    unique case (rate_r)
      RATE_1M:   tickLen = 20'(TICK_CYC / 2);
      RATE_250K: tickLen = 20'(TICK_CYC * 2);
      RATE_300K: tickLen = 20'(TICK_CYC * 5 / 3);
      default:   tickLen = 20'(TICK_CYC);
    endcase
    stepTicks   = STEP_BASE_TICKS - {5'h00, stepCode_r};
    loadTicks   = (loadCode_r == 7'h00) ? ZERO_CODE_TICKS : {1'b0, loadCode_r, 1'b0};
    unloadTicks = (unloadCode_r == 4'h0) ? ZERO_CODE_TICKS : {1'b0, unloadCode_r, 4'h0};
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_r <= 20'h00000;
      tick_r    <= 1'b0;
    end else begin
      tick_r    <= (tickCnt_r >= tickLen - 20'h00001);
      tickCnt_r <= (tickCnt_r >= tickLen - 20'h00001) ? 20'h00000 : tickCnt_r + 20'h00001;
    end
  end

  // free-running step clock: the first interval after a start may be shorter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stepTmr_r <= 9'h000;
      stepNow_r <= 1'b0;
    end else begin
      stepNow_r <= 1'b0;
      if (tick_r) begin
        if (stepTmr_r <= 9'h001) begin
          stepTmr_r <= stepTicks;
          stepNow_r <= 1'b1;
        end else begin
          stepTmr_r <= stepTmr_r - 9'h001;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // head positioning, all drives step on the same interval
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int d = 0; d < 4; d++) begin
        pcn_r[d]      <= 8'h00;
        ncn_r[d]      <= 8'h00;
        posMode_r[d]  <= POS_IDLE;
        recalCnt_r[d] <= 7'h00;
        drvSt0_r[d]   <= 8'h00;
      end
      doneEv_r   <= 4'h0;
      stepPulse  <= 4'h0;
      stepDir    <= 4'h0;
      pulseCnt_r <= 8'h00;
    end else begin
      doneEv_r <= 4'h0;
      if (pulseCnt_r != 8'h00) begin
        pulseCnt_r <= pulseCnt_r - 8'h01;
      end else begin
        stepPulse <= 4'h0;
      end
      for (int d = 0; d < 4; d++) begin
        if (lpExit) begin
          pcn_r[d]     <= 8'h00;
          drvSt0_r[d]  <= 8'h00;
          posMode_r[d] <= POS_IDLE;
        end else if (inCmd && cmdDrv_r == 2'(d) && posMode_r[d] == POS_IDLE
                     && (cmdOp_r == OP_SEEK || cmdOp_r == OP_RECAL)) begin
          ncn_r[d]      <= cmdCyl_r;
          recalCnt_r[d] <= 7'h00;
          if (cmdOp_r == OP_RECAL) begin
            pcn_r[d]     <= 8'h00;
            posMode_r[d] <= POS_RECAL;
          end else begin
            posMode_r[d] <= POS_SEEK;
          end
        end else if (stepNow_r && posMode_r[d] == POS_SEEK) begin
          if (pcn_r[d] == ncn_r[d]) begin
            drvSt0_r[d]  <= {IC_NORMAL, 1'b1, 1'b0, 2'b00, 2'(d)};
            doneEv_r[d]  <= 1'b1;
            posMode_r[d] <= POS_IDLE;
          end else begin
            stepPulse[d] <= 1'b1;
            stepDir[d]   <= (pcn_r[d] < ncn_r[d]);
            pcn_r[d]     <= (pcn_r[d] < ncn_r[d]) ? pcn_r[d] + 8'h01 : pcn_r[d] - 8'h01;
          end
        end else if (stepNow_r && posMode_r[d] == POS_RECAL) begin
          if (trackZero[d]) begin
            drvSt0_r[d]  <= {IC_NORMAL, 1'b1, 1'b0, 2'b00, 2'(d)};
            doneEv_r[d]  <= 1'b1;
            posMode_r[d] <= POS_IDLE;
          end else if (recalCnt_r[d] == RECAL_MAX_STEPS) begin
            drvSt0_r[d]  <= {IC_ABNORMAL, 1'b1, 1'b1, 2'b00, 2'(d)};
            doneEv_r[d]  <= 1'b1;
            posMode_r[d] <= POS_IDLE;
          end else begin
            stepPulse[d]  <= 1'b1;
            stepDir[d]    <= 1'b0;
            recalCnt_r[d] <= recalCnt_r[d] + 7'h01;
          end
        end
      end
      if (stepNow_r) begin
        pulseCnt_r <= 8'(STEP_PULSE_CYC);
      end
    end
  end

  // ------------------------------------------------------------
  // command sequencer, results and interrupt sources
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r     <= ST_IDLE;
      cmdOp_r     <= 4'h0;
      cmdDrv_r    <= 2'h0;
      cmdCyl_r    <= 8'h00;
      idCap_r     <= 32'h0000_0000;
      idxCnt_r    <= 2'h0;
      resSt0_r    <= 8'h00;
      resPcn_r    <= 8'h00;
      resSt1_r    <= 8'h00;
      st3_r       <= 8'h00;
      drvPend_r   <= 4'h0;
      // a single polling interrupt follows reset
      pollPend_r  <= 1'b1;
      otherPend_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (cmdWr) begin
            cmdOp_r  <= pwdata[CMD_OP_LSB +: 4];
            cmdDrv_r <= pwdata[CMD_DRV_LSB +: 2];
            cmdCyl_r <= pwdata[CMD_CYL_LSB +: 8];
            state_r  <= ST_CMD;
          end
        end
        ST_CMD: begin
          state_r <= ST_IDLE;
          if (cmdOp_r == OP_READID) begin
            idxCnt_r <= 2'h0;
            state_r  <= ST_RDID;
          end else if (cmdOp_r == OP_SENSEDRV) begin
            st3_r <= {3'b000, trackZero[cmdDrv_r], indexPulse, 1'b0, cmdDrv_r};
          end else if (cmdOp_r == OP_SENSEINT) begin
            // priority: polling, then lowest drive, then data-path events
            if (pollPend_r) begin
              pollPend_r <= 1'b0;
              resSt0_r   <= {IC_POLL, 6'h00};
            end else if (drvPend_r != 4'h0) begin
              for (int d = 3; d >= 0; d--) begin
                if (drvPend_r[d]) begin
                  resSt0_r <= drvSt0_r[d];
                  resPcn_r <= pcn_r[d];
                end
              end
              drvPend_r <= drvPend_r & (drvPend_r - 4'h1);
            end else if (otherPend_r) begin
              otherPend_r <= 1'b0;
            end else begin
              resSt0_r <= {IC_INVALID, 6'h00};
            end
          end
        end
        ST_RDID: begin
          if (idValid) begin
            idCap_r     <= idField;
            resSt0_r    <= {IC_NORMAL, 3'b000, 1'b0, cmdDrv_r};
            resSt1_r    <= 8'h00;
            otherPend_r <= 1'b1;
            state_r     <= ST_IDLE;
          end else if (idxRise && idxCnt_r == 2'h1) begin
            resSt0_r    <= {IC_ABNORMAL, 3'b000, 1'b0, cmdDrv_r};
            resSt1_r    <= 8'h01;
            otherPend_r <= 1'b1;
            state_r     <= ST_IDLE;
          end else if (idxRise) begin
            idxCnt_r <= idxCnt_r + 2'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // new events win over a sense in the same cycle
      drvPend_r <= (inCmd && cmdOp_r == OP_SENSEINT && !pollPend_r)
                   ? ((drvPend_r & (drvPend_r - 4'h1)) | doneEv_r)
                   : (drvPend_r | doneEv_r);
      if (resultEnter) begin
        otherPend_r <= 1'b1;
      end
      if (lpExit) begin
        resSt0_r    <= 8'h00;
        resPcn_r    <= 8'h00;
        resSt1_r    <= 8'h00;
        st3_r       <= 8'h00;
        idCap_r     <= 32'h0000_0000;
        drvPend_r   <= 4'h0;
        pollPend_r  <= 1'b0;
        otherPend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      idxDly_r <= 1'b0;
      lowDly_r <= 1'b0;
    end else begin
      idxDly_r <= indexPulse;
      lowDly_r <= lowPower;
    end
  end

  // ------------------------------------------------------------
  // interrupt and transfer signalling
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      intOut          <= 1'b0;
      transferRequest <= 1'b0;
      transferIntr    <= 1'b0;
      gap2Len         <= GAP2_CONV_BYTES;
    end else begin
      transferRequest <= byteReq & ~nonDma_r;
      transferIntr    <= byteReq & nonDma_r;
      intOut          <= pollPend_r | otherPend_r | (|drvPend_r) | transferIntr;
      gap2Len         <= perp_r ? GAP2_PERP_BYTES : GAP2_CONV_BYTES;
    end
  end

  // ------------------------------------------------------------
  // head load and unload delays
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      headLoad    <= 1'b0;
      headReady   <= 1'b0;
      headTmr_r   <= 9'h000;
      unloading_r <= 1'b0;
    end else if (rwStart) begin
      headLoad    <= 1'b1;
      unloading_r <= 1'b0;
      if (!headReady) begin
        headTmr_r <= loadTicks;
      end
    end else if (rwEnd && headLoad) begin
      unloading_r <= 1'b1;
      headTmr_r   <= unloadTicks;
    end else if (tick_r && headTmr_r != 9'h000) begin
      headTmr_r <= headTmr_r - 9'h001;
      if (headTmr_r == 9'h001) begin
        headReady <= ~unloading_r;
        headLoad  <= ~unloading_r;
        unloading_r <= 1'b0;
      end
    end
  end

endmodule : fcc_ctrl_unit

`default_nettype wire

// >>> core/fcc_pkg.sv
// fcc_pkg: register map, field layout, codes and timing of the floppy control command unit
// assumes a 100 MHz system clock and an APB master with 32-bit data
package fcc_pkg;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_CMD     = 8'h00;
  localparam logic [7:0]  OFF_TIMING  = 8'h04;
  localparam logic [7:0]  OFF_STATUS  = 8'h08;
  localparam logic [7:0]  OFF_RESULT  = 8'h0C;
  localparam logic [7:0]  OFF_IDCAP   = 8'h10;
  localparam logic [7:0]  OFF_CYL     = 8'h14;
  localparam logic [7:0]  OFF_DRVST   = 8'h18;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CMD_OP_LSB     = 0;
  localparam int CMD_DRV_LSB    = 4;
  localparam int CMD_CYL_LSB    = 8;
  localparam int TIM_STEP_LSB   = 0;
  localparam int TIM_UNLOAD_LSB = 4;
  localparam int TIM_LOAD_LSB   = 8;
  localparam int TIM_MODE_BIT   = 15;
  localparam int TIM_RATE_LSB   = 16;
  localparam int TIM_PERP_BIT   = 18;
  localparam int ST0_SE_BIT     = 5;
  localparam int ST0_EC_BIT     = 4;
  localparam int ST0_HEAD_BIT   = 2;
  localparam int ST3_TRK0_BIT   = 4;
  localparam int ST3_IDX_BIT    = 3;

  // ------------------------------------------------------------
  // command codes, cause codes, data rates
  // ------------------------------------------------------------
  localparam logic [3:0] OP_SEEK     = 4'h1;
  localparam logic [3:0] OP_RECAL    = 4'h2;
  localparam logic [3:0] OP_READID   = 4'h3;
  localparam logic [3:0] OP_SENSEINT = 4'h4;
  localparam logic [3:0] OP_SENSEDRV = 4'h5;

  localparam logic [1:0] IC_NORMAL   = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_INVALID  = 2'h2;
  localparam logic [1:0] IC_POLL     = 2'h3;

  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M   = 2'h3;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [3:0] STEP_CODE_RST   = 4'h0;
  localparam logic [3:0] UNLOAD_CODE_RST = 4'h0;
  localparam logic [6:0] LOAD_CODE_RST   = 7'h00;
  localparam logic [1:0] RATE_RST        = RATE_500K;

  // ------------------------------------------------------------
  // timing: one tick is 1 ms at 500 kbps and scales with the rate
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYC_DEF   = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned STEP_PULSE_NS  = 1000;
  localparam int unsigned STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0]  STEP_BASE_TICKS = 9'h010;
  localparam logic [8:0]  ZERO_CODE_TICKS = 9'h100;
  localparam logic [6:0]  RECAL_MAX_STEPS = 7'h4F;
  localparam logic [5:0]  GAP2_CONV_BYTES = 6'h16;
  localparam logic [5:0]  GAP2_PERP_BYTES = 6'h29;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMD  = 3'b010,
    ST_RDID = 3'b100
  } fcc_state_t;

endpackage : fcc_pkg

// >>> test/fcc_chk_assertions.sv
// fcc_chk: port-level checks of the control command unit
// assumes it is bound to fcc_ctrl_unit and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module fcc_chk (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [3:0]  stepPulse,
  input wire logic [3:0]  stepDir,
  input wire logic        intOut,
  input wire logic        transferRequest,
  input wire logic        transferIntr,
  input wire logic        resultEnter,
  input wire logic        byteReq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_access; psel && $rose(penable); endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  chk_one_wait: assert property (s_access |=> s_answer)
    else $error("apb answer not after one wait state");
  chk_err_pair: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  chk_data_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero outside answer");
  chk_step_width: assert property ($rose(stepPulse[0]) |-> stepPulse[0] [*8])
    else $error("step pulse too short");
  chk_dir_steady: assert property (stepPulse[0] && $past(stepPulse[0]) |-> $stable(stepDir[0]))
    else $error("direction moved during step");
  chk_mode_excl: assert property (!(transferRequest && transferIntr))
    else $error("both transfer signals active");
  chk_dma_cause: assert property ($rose(transferRequest) |-> $past(byteReq))
    else $error("transfer request without byte request");
  chk_int_result: assert property (resultEnter |-> ##[1:3] intOut)
    else $error("no interrupt on result phase");
  chk_int_byte: assert property (transferIntr |-> ##[0:2] intOut)
    else $error("no interrupt on non-dma byte request");
endmodule : fcc_chk
bind fcc_ctrl_unit fcc_chk fcc_chk_inst (.*);
`default_nettype wire

// >>> test/fcc_drive_model.sv
// fcc_drive_model: four drive heads that follow step pulses and report track zero
// assumes registered step and direction outputs; stuck holds track zero low
`timescale 1ns/1ps
`default_nettype none
module fcc_drive_model (
  input  wire logic [3:0] stepPulse,
  input  wire logic [3:0] stepDir,
  input  wire logic [3:0] stuck,
  output wire logic [3:0] trackZero
);
  int pos [4] = '{2, 2, 2, 2};
  for (genvar i = 0; i < 4; i++) begin : g_drv
    // the head cannot move outward past the stop
    // moving on the trailing edge reads a direction that settled long before
    always @(negedge stepPulse[i]) pos[i] <= stepDir[i] ? pos[i] + 1 : (pos[i] > 0 ? pos[i] - 1 : 0);
    assign trackZero[i] = (pos[i] == 0) && !stuck[i];
  end
endmodule : fcc_drive_model
`default_nettype wire

// >>> test/testbench.sv
// testbench: drives the control command unit over apb, drive model on the far side
// assumes fcc_pkg, the design, the drive model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  import fcc_pkg::*;
  logic        sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready;
  logic        indexPulse = 0, idValid = 0, lowPower = 0, resultEnter = 0, byteReq = 0;
  logic        rwStart = 0, rwEnd = 0, intOut, transferRequest, transferIntr, errSeen;
  logic        headLoad, headReady;
  logic [5:0]  gap2Len;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, idField = 32'h0, prdata, r;
  logic [3:0]  trackZero, stepPulse, stepDir, stuck = 4'h0;
  int          failures = 0, samples_checked = 0, steps;
  always #5 sys_clk = ~sys_clk;
  // short tick keeps the 79-step recalibrate inside the run budget
  fcc_ctrl_unit #(.TICK_CYC(20)) fcc_ctrl_unit_inst (.*);
  fcc_drive_model fcc_drive_model_inst (.*);
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk) penable <= 1'b1;
    do @(posedge sys_clk) n++; while (pready !== 1'b1 && n < 20);
    r = prdata; errSeen = pslverr;
    if (n >= 20) begin failures++; close_out(); end
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic sense();
    apb(1'b1, OFF_CMD, {28'h0, OP_SENSEINT});
    apb(1'b0, OFF_RESULT, 32'h0);
  endtask : sense
  task automatic wait_int(input int drv, input int lim);
    int n;
    logic p;
    n = 0; steps = 0; p = stepPulse[drv];
    while (intOut !== 1'b1 && n < lim) begin
      @(posedge sys_clk) n++;
      if (stepPulse[drv] === 1'b1 && p !== 1'b1) steps++;
      p = stepPulse[drv];
    end
    if (n >= lim) begin failures++; close_out(); end
  endtask : wait_int
  task automatic t_seek(input logic [1:0] drv, input logic [7:0] cyl, input logic dir);
    apb(1'b1, OFF_CMD, {16'h0, cyl, 2'b00, drv, OP_SEEK});
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(r[0], 1'b0)
    wait_int(drv, 20000);
    `CHK(stepDir[drv], dir)
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(r[4:1], 4'h1 << drv)
    sense();
    `CHK(r[7:0], {6'h08, drv})
    `CHK(r[15:8], cyl)
  endtask : t_seek
  task automatic t_recal(input logic [1:0] drv, input int expSteps, input logic [7:0] st0);
    apb(1'b1, OFF_CMD, {26'h0, drv, OP_RECAL});
    wait_int(drv, 20000);
    `CHK(steps, expSteps)
    `CHK(stepDir[drv], 1'b0)
    sense();
    `CHK(r[7:0], st0)
    `CHK(r[15:8], 8'h00)
  endtask : t_recal
  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    apb(1'b1, OFF_TIMING, 32'h0000_0008);
    sense();
    `CHK(r[7:0], 8'hC0)
    `CHK(intOut, 1'b0)
    t_recal(2'd0, 2, 8'h20);
    apb(1'b1, OFF_CMD, {28'h0, OP_SENSEDRV});
    apb(1'b0, OFF_DRVST, 32'h0);
    `CHK(r[4:0], 5'h10)
    `CHK(intOut, 1'b0)
    t_seek(2'd0, 8'h03, 1'b1);
    t_seek(2'd0, 8'h01, 1'b0);
    @(posedge sys_clk) lowPower <= 1'b1;
    @(posedge sys_clk) lowPower <= 1'b0;
    apb(1'b0, OFF_CYL, 32'h0);
    `CHK(r, 32'h0000_0000)
    stuck <= 4'h4;
    t_recal(2'd2, 79, 8'h72);
    apb(1'b1, OFF_CMD, {28'h0, OP_READID});
    @(posedge sys_clk) begin idField <= 32'h0312_0502; idValid <= 1'b1; end
    @(posedge sys_clk) idValid <= 1'b0;
    wait_int(0, 200);
    apb(1'b0, OFF_IDCAP, 32'h0);
    `CHK(r, 32'h0312_0502)
    sense();
    apb(1'b1, OFF_CMD, {28'h0, OP_READID});
    repeat (2) begin
      @(posedge sys_clk) indexPulse <= 1'b1;
      @(posedge sys_clk) indexPulse <= 1'b0;
    end
    wait_int(0, 200);
    apb(1'b0, OFF_RESULT, 32'h0);
    `CHK(r[7:6], IC_ABNORMAL)
    `CHK(r[23:16], 8'h01)
    sense();
    apb(1'b0, 8'h40, 32'h0);
    `CHK({errSeen, r}, 33'h1_0000_0000)
    @(posedge sys_clk) byteReq <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK({transferRequest, transferIntr}, 2'b10)
    apb(1'b1, OFF_TIMING, 32'h0000_8008);
    repeat (3) @(posedge sys_clk);
    `CHK({transferRequest, transferIntr, intOut}, 3'b011)
    @(posedge sys_clk) begin byteReq <= 1'b0; resultEnter <= 1'b1; end
    @(posedge sys_clk) resultEnter <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // load code 1 (2 ticks), unload code 1 (16 ticks), perpendicular gap
    apb(1'b1, OFF_TIMING, 32'h0004_8118);
    repeat (2) @(posedge sys_clk);
    `CHK(gap2Len, GAP2_PERP_BYTES)
    @(posedge sys_clk) rwStart <= 1'b1;
    @(posedge sys_clk) rwStart <= 1'b0;
    repeat (8) @(posedge sys_clk);
    `CHK({headLoad, headReady}, 2'b10)
    repeat (60) @(posedge sys_clk);
    `CHK({headLoad, headReady}, 2'b11)
    @(posedge sys_clk) rwEnd <= 1'b1;
    @(posedge sys_clk) rwEnd <= 1'b0;
    repeat (400) @(posedge sys_clk);
    `CHK({headLoad, headReady}, 2'b00)
    close_out();
  end
endmodule : testbench
`default_nettype wire
